// file: hdl/csie_core.sv
`timescale 1ns/1ps
// Summary of operation
// [R1] halt clears whole status register, cpu stops
// [R2] firmware writes zero to reserved bit one
// [R3] enable sense read-only, changed by instructions
// [R4] suspend write stops cpu, enters low power
// [R5] enabled pending or bus activity wakes device
// [R6] suspend write ignored during bus activity
// [R7] power-on reset sets power-on flag
// [R8] long single-ended zero sets bus-reset flag
// [R9] watchdog reset sets watchdog flag
// [R10] pending bit shows any active interrupt
// [R11] power-up value is 00010001
// [R12] start-up suspend 96 ms, watchdog after 8 ms
// [R13] firmware clears power-on flag after start-up
// [R14] watchdog loads 01xx0001, keeps por and busreset
// [R15] each source maskable by its enable bit
// [R16] bits one, two gate timer ticks
// [R17] bits zero, three, five, six gate others
// [R18] any reset clears interrupt enables
// [R19] per-source pending latch, gated by enable
// [R20] reserved enable bits read zero
module csie_core #(
  parameter int WDT_CYCLES     = csie_pkg::TIMEOUT_INTERVAL_CYCLES,
  parameter int STARTUP_CYCLES = csie_pkg::STARTUP_CYCLES,
  parameter int SE0_CYCLES     = csie_pkg::SE0_CYCLES
) (
  // clock and reset
  input  wire logic       sys_clk,
  input  wire logic       reset,
  // io port access from the cpu
  input  wire logic       io_port_write_instruction,
  input  wire logic       io_read,
  input  wire logic [7:0] io_addr,
  input  wire logic [7:0] io_wdata,
  output logic      [7:0] io_rdata,
  // cpu instruction events
  input  wire logic       halt_instr,
  input  wire logic       irq_mask_instruction,
  input  wire logic       irq_unmask_instruction,
  input  wire logic       return_from_isr_instruction,
  input  wire logic       irq_ack,
  // watchdog
  input  wire logic       wdt_reset,
  // interrupt sources
  input  wire logic       tick_128us,
  input  wire logic       tick_1ms,
  input  wire logic       hub_change,
  input  wire logic       gpio_edge,
  input  wire logic       i2c_event,
  input  wire logic       usb_bus_activity,
  // upstream pins
  input  wire logic       usb_dp,
  input  wire logic       usb_dm,
  // cpu control outputs
  output logic            cpu_run,
  output logic            suspended,
  output logic            irq_request,
  output logic      [2:0] irq_id
);

  localparam int CW = csie_pkg::SU_CNT_W;
  localparam logic [CW-1:0] WDT_LAST     = CW'(WDT_CYCLES - 1);
  localparam logic [CW-1:0] STARTUP_LAST = CW'(STARTUP_CYCLES - 1);
  localparam int SW = csie_pkg::SRC_COUNT;

  ////////////////////////////////////////////////////////////////////////////
  // state
  typedef struct packed {
    logic          run;                // run bit
    logic          suspend;            // suspend state
    logic          por;                // power-on reset flag
    logic          busrst;             // bus reset flag
    logic          timeout_reset_flag; // watchdog reset flag
    logic          gie;                // cpu interrupt enable
    logic [SW-1:0] gen;                // global interrupt enable register
    logic          startup;            // start-up suspend running
    logic [CW-1:0] su_cnt;             // start-up elapsed cycles
    logic [7:0]    rdata;              // read data
  } csie_core_state_type;

  // power-up value, power-on flag and run bit set
  localparam csie_core_state_type RESET_STATE = '{
    run: 1'b1, suspend: 1'b0, por: 1'b1, busrst: 1'b0, // [R7] [R11]
    timeout_reset_flag: 1'b0, gie: 1'b0,
    gen: csie_pkg::GIE_RESET_VALUE, // [R18]
    startup: 1'b1, su_cnt: '0, rdata: 8'h00};

  csie_core_state_type st;      // registered state
  csie_core_state_type next_st; // next state

  logic          se0_pulse; // bus reset recognised
  logic [SW-1:0] pend;      // pending flags
  logic [SW-1:0] set_vec;   // source events
  logic [SW-1:0] clr_vec;   // serviced source
  logic [SW-1:0] req_vec;   // pending and enabled
  logic          wdt_evt;   // any watchdog reset
  logic          pend_flush; // clear all pending
  logic [7:0]    psc_read;  // status/control as read
  logic          wr_psc;    // write to status/control
  logic          wr_gie;    // write to enable register

  ////////////////////////////////////////////////////////////////////////////
  // bus reset detector and pending latches
  csie_se0_detect #(
    .COUNT (SE0_CYCLES)
  ) u_se0 (
    .sys_clk   (sys_clk),
    .reset     (reset),
    .usb_dp    (usb_dp),
    .usb_dm    (usb_dm),
    .se0_pulse (se0_pulse)
  );

  csie_pend_bank #(
    .WIDTH (SW)
  ) u_pend (
    .sys_clk (sys_clk),
    .reset   (reset),
    .set_req (set_vec),
    .clr_req (clr_vec),
    .flush   (pend_flush),
    .pend    (pend)
  );

  ////////////////////////////////////////////////////////////////////////////
  // source mapping, reserved positions never pend
  always_comb begin
    set_vec = '0;
    set_vec[csie_pkg::GIE_BUSRST] = se0_pulse;  // [R17]
    set_vec[csie_pkg::GIE_T128US] = tick_128us; // [R16]
    set_vec[csie_pkg::GIE_T1MS]   = tick_1ms;   // [R16]
    set_vec[csie_pkg::GIE_HUB]    = hub_change; // [R17]
    set_vec[csie_pkg::GIE_GPIO]   = gpio_edge;  // [R17]
    set_vec[csie_pkg::GIE_I2C]    = i2c_event;  // [R17]
  end

  ////////////////////////////////////////////////////////////////////////////
  // request and priority: lowest index wins
  always_comb begin
    req_vec = pend & st.gen; // [R15] [R19]
    irq_id  = 3'h0;
    for (int i = SW - 1; i >= 0; i--) begin
      if (req_vec[i]) begin
        irq_id = 3'(i);
      end
    end
    irq_request = st.gie && (req_vec != '0) && st.run && !st.startup; // [R19]
    clr_vec = '0;
    if (irq_ack && irq_request) begin
      clr_vec[irq_id] = 1'b1; // [R19]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // status/control as seen by a read
  always_comb begin
    psc_read = 8'h00;
    psc_read[csie_pkg::PSC_RUN]      = st.run;
    psc_read[csie_pkg::PSC_RSVD]     = 1'b0; // [R2]
    psc_read[csie_pkg::PSC_IE_SENSE] = st.gie; // [R3]
    psc_read[csie_pkg::PSC_SUSPEND]  = st.suspend;
    psc_read[csie_pkg::PSC_POR]      = st.por;
    psc_read[csie_pkg::PSC_BUSRST]   = st.busrst;
    psc_read[csie_pkg::PSC_WDR]      = st.timeout_reset_flag;
    psc_read[csie_pkg::PSC_PENDING]  = |pend; // [R10]
  end

  assign wr_psc  = io_port_write_instruction && (io_addr == csie_pkg::ADDR_PROC_STATUS_CTRL);
  assign wr_gie  = io_port_write_instruction && (io_addr == csie_pkg::ADDR_GLOBAL_IRQ_ENABLE);
  // external watchdog or the one that fires 8 ms into an unaborted start-up, which keeps running
  assign wdt_evt = wdt_reset || (st.startup && (st.su_cnt == WDT_LAST)); // [R9] [R12]
  assign pend_flush = wdt_evt || halt_instr; // [R18]

  ////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    next_st = st;
    // start-up suspend timing, aborted by a bus reset
    if (st.startup) begin
      next_st.su_cnt = st.su_cnt + 1'b1;
      if (se0_pulse || (st.su_cnt == STARTUP_LAST)) begin
        next_st.startup = 1'b0; // [R12]
      end
    end
    // firmware writes
    if (wr_psc) begin
      next_st.run                = io_wdata[csie_pkg::PSC_RUN];
      next_st.por                = io_wdata[csie_pkg::PSC_POR];
      next_st.busrst             = io_wdata[csie_pkg::PSC_BUSRST];
      next_st.timeout_reset_flag = io_wdata[csie_pkg::PSC_WDR];
      if (io_wdata[csie_pkg::PSC_SUSPEND] && !usb_bus_activity) begin
        next_st.suspend = 1'b1; // [R4] [R6]
      end
    end
    if (wr_gie) begin
      next_st.gen = io_wdata & csie_pkg::GIE_WRITE_MASK; // [R15] [R20]
    end
    // cpu interrupt enable, only by instructions
    if (irq_mask_instruction) begin
      next_st.gie = 1'b0; // [R3]
    end
    if (irq_unmask_instruction || return_from_isr_instruction) begin
      next_st.gie = 1'b1; // [R3]
    end
    if (irq_ack && irq_request) begin
      next_st.gie = 1'b0; // [R19]
    end
    // hardware set of the bus reset flag wins over a write
    if (se0_pulse) begin
      next_st.busrst = 1'b1; // [R8]
    end
    // wake from suspend
    if (st.suspend && ((req_vec != '0) || usb_bus_activity)) begin
      next_st.suspend = 1'b0; // [R5]
    end
    // halt clears every bit
    if (halt_instr) begin
      next_st.run                = 1'b0; // [R1]
      next_st.suspend            = 1'b0;
      next_st.por                = 1'b0;
      next_st.busrst             = 1'b0;
      next_st.timeout_reset_flag = 1'b0;
      next_st.gie                = 1'b0;
    end
    // watchdog reset keeps por and bus reset flags
    if (wdt_evt) begin
      next_st.run                = 1'b1; // [R14]
      next_st.suspend            = 1'b0;
      next_st.timeout_reset_flag = 1'b1; // [R9]
      next_st.gie                = 1'b0;
      next_st.gen                = csie_pkg::GIE_RESET_VALUE; // [R18]
      next_st.por                = st.por; // [R14]
      next_st.busrst             = st.busrst || se0_pulse;
    end
    // read data, unmapped addresses read zero
    if (io_read) begin
      if (io_addr == csie_pkg::ADDR_PROC_STATUS_CTRL) begin
        next_st.rdata = psc_read;
      end else if (io_addr == csie_pkg::ADDR_GLOBAL_IRQ_ENABLE) begin
        next_st.rdata = st.gen; // [R20]
      end else begin
        next_st.rdata = 8'h00;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register, power-on value on reset
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      st <= RESET_STATE; // [R11] [R18]
    end else begin
      st <= next_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  assign io_rdata  = st.rdata;
  assign cpu_run   = st.run && !st.suspend && !st.startup; // [R1] [R4]
  assign suspended = st.suspend || st.startup;

  ////////////////////////////////////////////////////////////////////////////
  // assertions
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  AST_HALT_CLEARS: assert property ( // [R1]
    halt_instr && !wdt_evt |=> (psc_read == 8'h00) && !cpu_run)
    else $error("halt did not clear status/control");

  AST_SENSE_RO: assert property ( // [R3]
    wr_psc && !irq_mask_instruction && !irq_unmask_instruction &&
    !return_from_isr_instruction && !irq_ack && !halt_instr && !wdt_evt
    |=> st.gie == $past(st.gie))
    else $error("write changed interrupt enable sense");

  AST_SUSPEND_ENTER: assert property ( // [R4]
    wr_psc && io_wdata[csie_pkg::PSC_SUSPEND] && !usb_bus_activity &&
    !halt_instr && !wdt_evt |=> st.suspend && !cpu_run)
    else $error("suspend write did not suspend");

  AST_SUSPEND_IGNORED: assert property ( // [R6]
    wr_psc && usb_bus_activity && !st.suspend |=> !st.suspend)
    else $error("suspend taken during bus activity");

  AST_WAKE: assert property ( // [R5]
    st.suspend && usb_bus_activity |=> !st.suspend)
    else $error("bus activity did not wake");

  AST_POR_VALUE: assert property ( // [R11]
    $fell(reset) |-> psc_read == csie_pkg::PSC_POR_VALUE && st.gen == 8'h00)
    else $error("wrong power-up value");

  AST_BUSRST_FLAG: assert property ( // [R8]
    se0_pulse && !halt_instr |=> st.busrst ##0 psc_read[csie_pkg::PSC_BUSRST])
    else $error("bus reset flag not set");

  AST_WDT_LOAD: assert property ( // [R14]
    wdt_evt && !io_port_write_instruction && !halt_instr && !se0_pulse
    |=> psc_read[7:6] == 2'b01 && psc_read[3:0] == 4'h1 && st.gen == 8'h00 &&
        st.por == $past(st.por) && st.busrst == $past(st.busrst))
    else $error("watchdog load wrong");

  AST_STARTUP_WDT: assert property ( // [R12]
    st.startup && st.su_cnt == WDT_LAST |=> st.timeout_reset_flag)
    else $error("start-up watchdog missing");

  AST_MASKED_STAYS: assert property ( // [R10]
    !halt_instr && !wdt_evt && !irq_ack |=> (pend & $past(pend)) == $past(pend))
    else $error("pending flag lost without service");

  AST_ACK_CLEARS: assert property ( // [R19]
    irq_ack && irq_request && !irq_unmask_instruction &&
    !return_from_isr_instruction |=> !st.gie)
    else $error("service did not mask interrupts");

  AST_GIE_RESERVED: assert property ( // [R20]
    wr_gie && !wdt_evt |=> st.gen == ($past(io_wdata) & 8'h6f))
    else $error("enable register write wrong");

  COV_WAKE:    cover property (st.suspend ##1 !st.suspend);
  COV_SERVICE: cover property (irq_request && irq_ack);
  COV_STARTUP: cover property (st.startup && se0_pulse);
  COV_BUSRST:  cover property (se0_pulse ##1 st.busrst);

endmodule

// file: hdl/csie_pkg.sv
package csie_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // io port addresses
  localparam logic [7:0] ADDR_GLOBAL_IRQ_ENABLE = 8'h20; // global interrupt enable
  localparam logic [7:0] ADDR_PROC_STATUS_CTRL  = 8'hff; // processor status/control

  ////////////////////////////////////////////////////////////////////////////
  // processor status/control bit positions
  localparam int PSC_RUN      = 0; // run bit
  localparam int PSC_RSVD     = 1; // reserved, reads zero
  localparam int PSC_IE_SENSE = 2; // cpu interrupt enable sense
  localparam int PSC_SUSPEND  = 3; // suspend request / state
  localparam int PSC_POR      = 4; // power-on reset flag
  localparam int PSC_BUSRST   = 5; // usb bus reset flag
  localparam int PSC_WDR      = 6; // watchdog reset flag
  localparam int PSC_PENDING  = 7; // any interrupt pending

  // power-on value of processor status/control
  localparam logic [7:0] PSC_POR_VALUE = 8'h11;

  ////////////////////////////////////////////////////////////////////////////
  // global interrupt enable bit positions (also pending vector positions)
  localparam int GIE_BUSRST  = 0; // usb bus reset
  localparam int GIE_T128US  = 1; // 128 us timer tick
  localparam int GIE_T1MS    = 2; // 1.024 ms timer tick
  localparam int GIE_HUB     = 3; // hub status change
  localparam int GIE_GPIO    = 5; // any gpio edge
  localparam int GIE_I2C     = 6; // i2c activity
  localparam int SRC_COUNT   = 8; // width of enable and pending vectors

  // writable positions of global interrupt enable, reserved bits excluded
  localparam logic [7:0] GIE_WRITE_MASK  = 8'h6f;
  localparam logic [7:0] GIE_RESET_VALUE = 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // timing
  localparam int CLK_PERIOD_NS        = 20;    // sys_clk period
  localparam int SE0_MIN_NS           = 12000; // shortest recognised bus reset
  localparam int SE0_CYCLES           = (SE0_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TIMEOUT_INTERVAL_MS  = 8;     // watchdog interval
  localparam int TIMEOUT_INTERVAL_CYCLES = TIMEOUT_INTERVAL_MS * 1000000 / CLK_PERIOD_NS;
  localparam int STARTUP_SUSPEND_MS   = 96;    // start-up suspend length
  localparam int STARTUP_CYCLES       = STARTUP_SUSPEND_MS * 1000000 / CLK_PERIOD_NS;
  localparam int SU_CNT_W             = 23;    // start-up counter width

endpackage

// file: hdl/csie_pend_bank.sv
`timescale 1ns/1ps
module csie_pend_bank #(
  parameter int WIDTH = 8
) (
  // clock and reset
  input  wire logic             sys_clk,
  input  wire logic             reset,
  // per-source requests
  input  wire logic [WIDTH-1:0] set_req,
  input  wire logic [WIDTH-1:0] clr_req,
  input  wire logic             flush,
  // pending flags
  output logic      [WIDTH-1:0] pend
);

  ////////////////////////////////////////////////////////////////////////////
  // state
  typedef struct packed {
    logic [WIDTH-1:0] flags; // one pending flip-flop per source
  } csie_pend_state_type;

  csie_pend_state_type st;      // registered state
  csie_pend_state_type next_st; // next state

  ////////////////////////////////////////////////////////////////////////////
  // next state: set wins over clear, flush clears all
  always_comb begin
    next_st = st;
    next_st.flags = (st.flags & ~clr_req) | set_req; // [R19]
    if (flush) begin
      next_st.flags = '0; // [R19]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign pend = st.flags;

endmodule

// file: hdl/csie_se0_detect.sv
`timescale 1ns/1ps
module csie_se0_detect #(
  parameter int COUNT = csie_pkg::SE0_CYCLES
) (
  // clock and reset
  input  wire logic sys_clk,
  input  wire logic reset,
  // upstream data line pins
  input  wire logic usb_dp,
  input  wire logic usb_dm,
  // one pulse per recognised bus reset
  output logic      se0_pulse
);

  localparam int CW = $clog2(COUNT + 1);
  localparam logic [CW-1:0] LAST = CW'(COUNT - 1);

  ////////////////////////////////////////////////////////////////////////////
  // state
  typedef struct packed {
    logic          dp_s1; // first sync stage
    logic          dp_s2; // second sync stage
    logic          dm_s1; // first sync stage
    logic          dm_s2; // second sync stage
    logic [CW-1:0] cnt;   // se0 length counter
    logic          done;  // this se0 already reported
    logic          pulse; // registered event
  } csie_se0_state_type;

  csie_se0_state_type st;      // registered state
  csie_se0_state_type next_st; // next state

  ////////////////////////////////////////////////////////////////////////////
  // next state: count cycles with both lines low
  always_comb begin
    next_st = st;
    next_st.dp_s1 = usb_dp;
    next_st.dp_s2 = st.dp_s1;
    next_st.dm_s1 = usb_dm;
    next_st.dm_s2 = st.dm_s1;
    next_st.pulse = 1'b0;
    if (!st.dp_s2 && !st.dm_s2) begin
      // single-ended zero present
      if (!st.done) begin
        next_st.cnt = st.cnt + 1'b1;
        if (st.cnt == LAST) begin
          next_st.done  = 1'b1;
          next_st.pulse = 1'b1; // [R8]
        end
      end
    end else begin
      // any line high restarts the measurement
      next_st.cnt  = '0;
      next_st.done = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register; plus line idles high, minus line low after reset
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      st <= '{dp_s1: 1'b1, dp_s2: 1'b1, dm_s1: 1'b0, dm_s2: 1'b0,
              cnt: '0, done: 1'b0, pulse: 1'b0};
    end else begin
      st <= next_st;
    end
  end

  assign se0_pulse = st.pulse;

endmodule

// file: testbench/csie_cpu_model.sv
`timescale 1ns/1ps
// firmware side of the io bus: one-cycle strobes launched on the falling edge
module csie_cpu_model (
  // clock
  input  wire logic       sys_clk,
  // io bus towards the core
  output logic            io_port_write_instruction,
  output logic            io_read,
  output logic      [7:0] io_addr,
  output logic      [7:0] io_wdata,
  input  wire logic [7:0] io_rdata
);
  // idle bus at time zero
  initial begin
    io_port_write_instruction = 1'b0;
    io_read                   = 1'b0;
    io_addr                   = 8'h00;
    io_wdata                  = 8'h00;
  end

  ////////////////////////////////////////////////////////////////////////////
  // write one port, strobe stands across exactly one rising edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    io_addr                   = a;
    // reserved status bit always goes out as zero
    io_wdata                  = (a == csie_pkg::ADDR_PROC_STATUS_CTRL) ? (d & 8'hfd) : d;
    io_port_write_instruction = 1'b1;
    @(negedge sys_clk);
    io_port_write_instruction = 1'b0;
    // released data lines stop showing the last value
    io_wdata                  = ~io_wdata;
  endtask

  // read one port, data registered on the strobe edge
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge sys_clk);
    io_addr = a;
    io_read = 1'b1;
    @(negedge sys_clk);
    io_read = 1'b0;
    d       = io_rdata;
    io_addr = ~a;
  endtask
endmodule

// file: testbench/test_cpu_status_and_interrupt_enable.sv
`timescale 1ns/1ps
`define CSIE_CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin miscompares++; $display("[FAIL] %s exp %h got %h", nm, e, g); end end
module test_cpu_status_and_interrupt_enable;
  // clock, reset and stimulus
  logic        sys_clk;
  logic        reset;
  logic [10:0] ev;               // halt,mask,unmask,return_from_isr_instruction,ack,wdt,t128,t1ms,hub,gpio,i2c
  logic        usb_bus_activity; // bus activity level
  logic        usb_dp;           // upstream plus line
  logic        usb_dm;           // upstream minus line
  // io bus and outputs
  logic        io_wr;
  logic        io_read;
  logic [7:0]  io_addr;
  logic [7:0]  io_wdata;
  logic [7:0]  io_rdata;
  logic        cpu_run;
  logic        suspended;
  logic        irq_request;
  logic [2:0]  irq_id;
  // bookkeeping
  int          miscompares;
  int          n_compared;
  int          cycles;

  // firmware model on the io bus
  csie_cpu_model csie_cpu_model_inst (.sys_clk(sys_clk), .io_port_write_instruction(io_wr),
    .io_read(io_read), .io_addr(io_addr), .io_wdata(io_wdata), .io_rdata(io_rdata));

  // core with shortened counts
  csie_core #(.WDT_CYCLES(20), .STARTUP_CYCLES(60), .SE0_CYCLES(8)) csie_core_inst (
    .sys_clk(sys_clk), .reset(reset), .io_port_write_instruction(io_wr), .io_read(io_read),
    .io_addr(io_addr), .io_wdata(io_wdata), .io_rdata(io_rdata), .halt_instr(ev[0]),
    .irq_mask_instruction(ev[1]), .irq_unmask_instruction(ev[2]),
    .return_from_isr_instruction(ev[3]), .irq_ack(ev[4]), .wdt_reset(ev[5]),
    .tick_128us(ev[6]), .tick_1ms(ev[7]), .hub_change(ev[8]), .gpio_edge(ev[9]),
    .i2c_event(ev[10]), .usb_bus_activity(usb_bus_activity), .usb_dp(usb_dp),
    .usb_dm(usb_dm), .cpu_run(cpu_run), .suspended(suspended), .irq_request(irq_request),
    .irq_id(irq_id));

  ////////////////////////////////////////////////////////////////////////////
  // 50 mhz clock
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  // hang guard, counts a mismatch and closes the run
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 3000) begin
      miscompares++;
      test_done();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // verdict
  task automatic test_done();
    $display("compared %0d, mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // one-cycle event strobe
  task automatic pulse(input int b);
    @(negedge sys_clk);
    ev[b] = 1'b1;
    @(negedge sys_clk);
    ev[b] = 1'b0;
  endtask

  // read a port and compare
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e, input string nm);
    logic [7:0] v;
    csie_cpu_model_inst.rd(a, v);
    `CSIE_CHK(nm, e, v)
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // power-up value, start-up watchdog, cleared enables
  task automatic t_startup();
    rd_chk(8'hff, 8'h11, "status at power-up");
    repeat (80) @(negedge sys_clk);
    rd_chk(8'hff, 8'h51, "status after start-up");
    rd_chk(8'h20, 8'h00, "enables after start-up");
    `CSIE_CHK("cpu_run", 1'b1, cpu_run)
  endtask

  // sense bit ignores writes, follows instructions
  task automatic t_sense();
    csie_cpu_model_inst.wr(8'hff, 8'h07);
    rd_chk(8'hff, 8'h01, "sense write ignored");
    pulse(2);
    rd_chk(8'hff, 8'h05, "sense after unmask");
    pulse(1);
    rd_chk(8'hff, 8'h01, "sense after mask");
  endtask

  // masking, reserved enables, pending latch and service
  task automatic t_mask();
    csie_cpu_model_inst.wr(8'h20, 8'hff);
    rd_chk(8'h20, 8'h6f, "reserved enables");
    csie_cpu_model_inst.wr(8'h20, 8'h00);
    pulse(6);
    pulse(2);
    `CSIE_CHK("masked request", 1'b0, irq_request)
    rd_chk(8'hff, 8'h85, "pending while masked");
    csie_cpu_model_inst.wr(8'h20, 8'h02);
    `CSIE_CHK("enabled request", 1'b1, irq_request)
    `CSIE_CHK("timer id", 3'h1, irq_id)
    pulse(1);
    `CSIE_CHK("request after mask", 1'b0, irq_request)
    pulse(2);
    pulse(4);
    rd_chk(8'hff, 8'h01, "after service");
  endtask

  // each source but bus reset raises a request with its own id, all enables set
  task automatic t_sources();
    int sb[5] = '{1, 2, 3, 5, 6};
    int eb[5] = '{6, 7, 8, 9, 10};
    csie_cpu_model_inst.wr(8'h20, 8'h6f);
    for (int i = 0; i < 5; i++) begin
      pulse(2);
      pulse(eb[i]);
      `CSIE_CHK("source request", 1'b1, irq_request)
      `CSIE_CHK("source id", 3'(sb[i]), irq_id)
      pulse(4);
    end
  endtask

  // suspend refused under activity, entered, woken by enabled pending
  task automatic t_suspend();
    @(negedge sys_clk);
    usb_bus_activity = 1'b1;
    csie_cpu_model_inst.wr(8'hff, 8'h09);
    `CSIE_CHK("suspend refused", 1'b0, suspended)
    usb_bus_activity = 1'b0;
    csie_cpu_model_inst.wr(8'hff, 8'h09);
    `CSIE_CHK("suspended", 1'b1, suspended)
    `CSIE_CHK("run while suspended", 1'b0, cpu_run)
    // one cycle of bus activity with nothing pending wakes the part
    usb_bus_activity = 1'b1;
    @(negedge sys_clk);
    usb_bus_activity = 1'b0;
    `CSIE_CHK("woken by activity", 1'b0, suspended)
    csie_cpu_model_inst.wr(8'hff, 8'h09);
    `CSIE_CHK("suspended again", 1'b1, suspended)
    pulse(9);
    for (int k = 0; k < 4 && suspended !== 1'b0; k++) @(negedge sys_clk);
    `CSIE_CHK("woken", 1'b0, suspended)
    `CSIE_CHK("run after wake", 1'b1, cpu_run)
  endtask

  // long single-ended zero: flag, top priority
  task automatic t_busreset();
    pulse(2);
    usb_dp = 1'b0;
    usb_dm = 1'b0;
    repeat (20) @(negedge sys_clk);
    usb_dp = 1'b1;
    rd_chk(8'hff, 8'ha5, "bus reset flag");
    `CSIE_CHK("bus reset id", 3'h0, irq_id)
  endtask

  // watchdog load keeps bus flag, then halt clears all
  task automatic t_wdt_halt();
    pulse(5);
    rd_chk(8'hff, 8'h61, "after watchdog");
    rd_chk(8'h20, 8'h00, "enables after watchdog");
    `CSIE_CHK("request after watchdog", 1'b0, irq_request)
    pulse(0);
    rd_chk(8'hff, 8'h00, "after halt");
    `CSIE_CHK("run after halt", 1'b0, cpu_run)
  endtask

  // second reset ends the halt, a bus reset cuts the start-up short
  task automatic t_abort();
    @(negedge sys_clk);
    reset  = 1'b1;
    usb_dp = 1'b0;
    repeat (4) @(negedge sys_clk);
    reset = 1'b0;
    repeat (30) @(negedge sys_clk);
    usb_dp = 1'b1;
    rd_chk(8'hff, 8'hb1, "status after aborted start-up");
    `CSIE_CHK("run after aborted start-up", 1'b1, cpu_run)
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    miscompares      = 0;
    n_compared       = 0;
    cycles           = 0;
    reset            = 1'b1;
    ev               = 11'h000;
    usb_bus_activity = 1'b0;
    usb_dp           = 1'b1;
    usb_dm           = 1'b0;
    repeat (16) @(negedge sys_clk);
    reset = 1'b0;
    t_startup();
    t_sense();
    t_mask();
    t_sources();
    t_suspend();
    t_busreset();
    t_wdt_halt();
    t_abort();
    test_done();
  end
endmodule
